// ===== hw/irpe_pkg.sv
package irpe_pkg;

   // ==========================================================================
   // widths
   localparam int MEAS_W = 32;
   localparam int ACC_W  = 32;
   localparam int TIME_W = 32;

   // ==========================================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_DELAY    = 8'h08;
   localparam logic [7:0] OFS_RUNTIME  = 8'h0C;
   localparam logic [7:0] OFS_IPK      = 8'h10;
   localparam logic [7:0] OFS_IRMS     = 8'h14;
   localparam logic [7:0] OFS_VPK      = 8'h18;
   localparam logic [7:0] OFS_VRMS     = 8'h1C;
   localparam logic [7:0] OFS_PWR      = 8'h20;
   localparam logic [7:0] OFS_BOUGHT   = 8'h24;
   localparam logic [7:0] OFS_SOLD     = 8'h28;
   localparam logic [7:0] OFS_CHARGE   = 8'h2C;
   localparam logic [7:0] OFS_DISCH    = 8'h30;
   localparam logic [7:0] OFS_TOTAL    = 8'h34;
   localparam logic [7:0] OFS_CFG      = 8'h38;

   // ==========================================================================
   // control bits (write one to act, self clearing)
   localparam int CTRL_CLR_BIT   = 0;
   localparam int CTRL_START_BIT = 1;
   localparam int CTRL_STOP_BIT  = 2;
   // configuration bits
   localparam int CFG_TIMED_BIT  = 0;
   localparam int CFG_DCONLY_BIT = 1;

   // ==========================================================================
   // reset values
   localparam logic [TIME_W-1:0] DELAY_RST   = 32'h0000_0000;
   localparam logic [TIME_W-1:0] RUNTIME_RST = 32'h0000_0000;
   localparam logic [1:0]        CFG_RST     = 2'h0;
   localparam logic [31:0]       RD_ZERO     = 32'h0000_0000;
   localparam logic [1:0]        RESP_OKAY   = 2'b00;
   localparam logic [1:0]        RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_RUN
   } irpe_state_t;

   // per-period measurement result
   typedef struct packed {
      logic [MEAS_W-1:0] i_pk;
      logic [MEAS_W-1:0] i_rms;
      logic [MEAS_W-1:0] v_pk;
      logic [MEAS_W-1:0] v_rms;
      logic [MEAS_W-1:0] pwr;
      logic [MEAS_W-1:0] dc_amps;
   } irpe_meas_t;

   // integration configuration
   typedef struct packed {
      logic              timed;
      logic              direct_only_input_setting;
      logic [TIME_W-1:0] delay;
      logic [TIME_W-1:0] runtime;
   } irpe_cfg_t;

endpackage

// ===== hw/irpe_top.sv
// Functional notes
// - clear command wipes all held inrush maxima.
// - held maximum replaced only by a strictly greater new value.
// - hold largest current peak and largest per-period rms current.
// - hold largest voltage peak and largest per-period rms voltage.
// - hold largest per-period power.
// - maxima use raw period results, not averaging_setting_a.
// - bought adds positive power, shown only outside direct-only coupling.
// - sold adds negative power, shown only outside direct-only coupling.
// - charge adds positive dc amps, shown only in direct-only coupling.
// - discharge adds negative dc amps, shown only in direct-only coupling.
// - result view selection never gates accumulation.
// - start applies pending configuration and begins integration together.
// - each start clears prior integration results first.
// - timed mode waits delay, runs run time, stops; manual stop anytime.
//
// Chosen here: the address map and the AXI4-Lite register port.
module irpe_top
   import irpe_pkg::*;
(
   // clock and reset
   input  wire logic                mclk_i,
   input  wire logic                rst_b_i,
   input  wire logic                clk_en_i,
   // measurement stream
   input  wire logic                meas_vld_i,
   input  wire irpe_meas_t          meas_i,
   input  wire logic                view_sel_i,
   // axi4-lite write address
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [7:0]          s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // axi4-lite write response
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output logic [1:0]               s_axi_bresp,
   // axi4-lite read address
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire logic [7:0]          s_axi_araddr,
   // axi4-lite read data
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   // status
   output logic                     integ_active_o
);

   // ==========================================================================
   // decode helpers
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a <= OFS_CFG) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [ACC_W-1:0] abs_val(input logic [MEAS_W-1:0] v);
      abs_val = v[MEAS_W-1] ? ACC_W'(-v) : ACC_W'(v);
   endfunction

   // ==========================================================================
   // state
   logic                aw_got_q, aw_got_d;
   logic                w_got_q, w_got_d;
   logic [7:0]          waddr_q, waddr_d;
   logic [31:0]         wdata_q, wdata_d;
   logic [3:0]          wstrb_q, wstrb_d;
   logic                bvalid_q, bvalid_d;
   logic [1:0]          bresp_q, bresp_d;
   logic                arready_q, arready_d;
   logic                rvalid_q, rvalid_d;
   logic [31:0]         rdata_q, rdata_d, rd_word;
   logic [1:0]          rresp_q, rresp_d;
   irpe_cfg_t           pend_q, pend_d;
   irpe_cfg_t           act_q, act_d;
   irpe_state_t         st_q, st_d;
   logic [TIME_W-1:0]   tmr_q, tmr_d;
   logic [MEAS_W-1:0]   hold_q [5], hold_d [5];
   logic [MEAS_W-1:0]   cur    [5];
   logic [ACC_W-1:0]    acc_q  [5], acc_d  [5];
   logic                wr_fire, clr_cmd, start_cmd, stop_cmd, accum;
   logic                awrdy_q, wrdy_q, actv_q;

   assign wr_fire   = aw_got_q && w_got_q && !bvalid_q;
   assign clr_cmd   = wr_fire && waddr_q == OFS_CTRL && wstrb_q[0] && wdata_q[CTRL_CLR_BIT];
   assign start_cmd = wr_fire && waddr_q == OFS_CTRL && wstrb_q[0] && wdata_q[CTRL_START_BIT];
   assign stop_cmd  = wr_fire && waddr_q == OFS_CTRL && wstrb_q[0] && wdata_q[CTRL_STOP_BIT];
   assign accum     = meas_vld_i && st_q == ST_RUN;

   // raw per-period results feed the maxima directly
   assign cur[0] = meas_i.i_pk;
   assign cur[1] = meas_i.i_rms;
   assign cur[2] = meas_i.v_pk;
   assign cur[3] = meas_i.v_rms;
   assign cur[4] = meas_i.pwr;

   // ==========================================================================
   // bus write path
   always_comb
   begin
      aw_got_d = aw_got_q;
      w_got_d  = w_got_q;
      waddr_d  = waddr_q;
      wdata_d  = wdata_q;
      wstrb_d  = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      pend_d   = pend_q;
      if (s_axi_awvalid && !aw_got_q)
      begin
         aw_got_d = 1'b1;
         waddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q)
      begin
         w_got_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         bvalid_d = 1'b1;
         bresp_d  = addr_known(waddr_q) ? RESP_OKAY : RESP_SLVERR;
         // configuration is only staged; the controller keeps it still while running
         if (st_q == ST_IDLE && wstrb_q[0])
         begin
            unique case (waddr_q)
               OFS_DELAY:   pend_d.delay = wdata_q;
               OFS_RUNTIME: pend_d.runtime = wdata_q;
               OFS_CFG:
               begin
                  pend_d.timed = wdata_q[CFG_TIMED_BIT];
                  pend_d.direct_only_input_setting = wdata_q[CFG_DCONLY_BIT];
               end
               default: ;
            endcase
         end
      end
      if (bvalid_q && s_axi_bready)
      begin
         bvalid_d = 1'b0;
         aw_got_d = 1'b0;
         w_got_d  = 1'b0;
      end
   end

   // ==========================================================================
   // bus read path
   always_comb
   begin
      unique case (s_axi_araddr)
         OFS_STATUS:  rd_word = {30'h0000_0000, st_q == ST_DELAY, st_q != ST_IDLE};
         OFS_DELAY:   rd_word = pend_q.delay;
         OFS_RUNTIME: rd_word = pend_q.runtime;
         OFS_IPK:     rd_word = hold_q[0];
         OFS_IRMS:    rd_word = hold_q[1];
         OFS_VPK:     rd_word = hold_q[2];
         OFS_VRMS:    rd_word = hold_q[3];
         OFS_PWR:     rd_word = hold_q[4];
         OFS_BOUGHT:  rd_word = act_q.direct_only_input_setting ? RD_ZERO : acc_q[0];
         OFS_SOLD:    rd_word = act_q.direct_only_input_setting ? RD_ZERO : acc_q[1];
         OFS_CHARGE:  rd_word = act_q.direct_only_input_setting ? acc_q[2] : RD_ZERO;
         OFS_DISCH:   rd_word = act_q.direct_only_input_setting ? acc_q[3] : RD_ZERO;
         OFS_TOTAL:   rd_word = acc_q[4];
         OFS_CFG:     rd_word = {30'h0000_0000, pend_q.direct_only_input_setting, pend_q.timed};
         default:     rd_word = RD_ZERO;
      endcase
      arready_d = 1'b0;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (s_axi_arvalid && !rvalid_q && !arready_q)
      begin
         arready_d = 1'b1;
         rvalid_d  = 1'b1;
         rdata_d   = rd_word;
         rresp_d   = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_d = 1'b0;
      end
   end

   // ==========================================================================
   // integration sequencer
   always_comb
   begin
      st_d  = st_q;
      tmr_d = tmr_q;
      act_d = act_q;
      if (start_cmd)
      begin
         act_d = pend_q;
         tmr_d = pend_q.delay;
         if (!pend_q.timed)
            st_d = ST_RUN;
         else if (pend_q.delay == '0)
         begin
            st_d  = ST_RUN;
            tmr_d = pend_q.runtime;
         end
         else
            st_d = ST_DELAY;
      end
      else if (stop_cmd)
         st_d = ST_IDLE;
      else
      begin
         unique case (st_q)
            ST_IDLE: ;
            ST_DELAY:
               if (tmr_q <= 32'h0000_0001)
               begin
                  st_d  = ST_RUN;
                  tmr_d = act_q.runtime;
               end
               else
                  tmr_d = tmr_q - 32'h0000_0001;
            ST_RUN:
               if (act_q.timed)
               begin
                  if (tmr_q <= 32'h0000_0001)
                     st_d = ST_IDLE;
                  tmr_d = tmr_q - 32'h0000_0001;
               end
         endcase
      end
   end

   // ==========================================================================
   // peak hold and accumulators
   generate
      for (genvar g = 0; g < 5; g++)
      begin : g_hold
         always_comb
         begin
            hold_d[g] = hold_q[g];
            if (clr_cmd)
               hold_d[g] = '0;
            else if (meas_vld_i && cur[g] > hold_q[g])
               hold_d[g] = cur[g];
         end
      end
   endgenerate

   always_comb
   begin
      for (int k = 0; k < 5; k++)
         acc_d[k] = acc_q[k];
      if (start_cmd)
      begin
         for (int k = 0; k < 5; k++)
            acc_d[k] = '0;
      end
      else if (accum)
      begin
         if (!meas_i.pwr[MEAS_W-1] && meas_i.pwr != '0)
            acc_d[0] = acc_q[0] + meas_i.pwr;
         if (meas_i.pwr[MEAS_W-1])
            acc_d[1] = acc_q[1] + abs_val(meas_i.pwr);
         if (!meas_i.dc_amps[MEAS_W-1] && meas_i.dc_amps != '0)
            acc_d[2] = acc_q[2] + meas_i.dc_amps;
         if (meas_i.dc_amps[MEAS_W-1])
            acc_d[3] = acc_q[3] + abs_val(meas_i.dc_amps);
         acc_d[4] = acc_q[4] + meas_i.pwr;
      end
   end

   // ==========================================================================
   // registers
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         waddr_q   <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
         pend_q    <= {CFG_RST, DELAY_RST, RUNTIME_RST};
         act_q     <= {CFG_RST, DELAY_RST, RUNTIME_RST};
         st_q      <= ST_IDLE;
         tmr_q     <= 32'h0000_0000;
         awrdy_q   <= 1'b1;
         wrdy_q    <= 1'b1;
         actv_q    <= 1'b0;
         for (int k = 0; k < 5; k++)
         begin
            hold_q[k] <= '0;
            acc_q[k]  <= '0;
         end
      end
      else if (clk_en_i)
      begin
         aw_got_q  <= aw_got_d;
         w_got_q   <= w_got_d;
         waddr_q   <= waddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         pend_q    <= pend_d;
         act_q     <= act_d;
         st_q      <= st_d;
         tmr_q     <= tmr_d;
         awrdy_q   <= !aw_got_d;
         wrdy_q    <= !w_got_d;
         actv_q    <= st_d != ST_IDLE;
         for (int k = 0; k < 5; k++)
         begin
            hold_q[k] <= hold_d[k];
            acc_q[k]  <= acc_d[k];
         end
      end
   end

   assign s_axi_awready  = awrdy_q;
   assign s_axi_wready   = wrdy_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rvalid   = rvalid_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign integ_active_o = actv_q;

   // ==========================================================================
   // checks
   AST_CLR_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      clr_cmd && clk_en_i |=> hold_q[0] == '0 && hold_q[4] == '0) else $error("clear did not zero maxima");
   AST_HOLD_MONO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !clr_cmd && clk_en_i |=> hold_q[1] >= $past(hold_q[1])) else $error("held rms current fell");
   AST_IPK_TRACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      clk_en_i && !clr_cmd && meas_vld_i && meas_i.i_pk > hold_q[0] |=> hold_q[0] == $past(meas_i.i_pk))
      else $error("peak current not captured");
   AST_VPK_TRACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      clk_en_i && !clr_cmd && meas_vld_i && meas_i.v_pk > hold_q[2] |=> hold_q[2] == $past(meas_i.v_pk))
      else $error("peak voltage not captured");
   AST_PWR_TRACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      clk_en_i && !clr_cmd && meas_vld_i && meas_i.pwr > hold_q[4] |=> hold_q[4] == $past(meas_i.pwr))
      else $error("power maximum not captured");
   AST_START_CLR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      start_cmd && clk_en_i |=> acc_q[4] == '0 && acc_q[0] == '0 && st_q != ST_IDLE)
      else $error("start did not clear results");
   AST_IDLE_FROZEN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_q == ST_IDLE && !start_cmd && clk_en_i |=> $stable(acc_q[4])) else $error("accumulated while stopped");
   AST_STOP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      stop_cmd && !start_cmd && clk_en_i |=> st_q == ST_IDLE) else $error("manual stop ignored");
   AST_SOLD_SIGN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      accum && clk_en_i && !start_cmd && !meas_i.pwr[MEAS_W-1] |=> $stable(acc_q[1]))
      else $error("sold grew on positive power");

endmodule

// ===== sim/tb_top.sv
module tb_top import irpe_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================================
   // signals
   typedef struct packed {
      logic [31:0] v;
      logic [31:0] e;
   } irpe_row_t;

   logic        mclk_i = 1'h0;
   logic        rst_b_i, clk_en_i, meas_vld_i, view_sel_i, integ_active_o;
   irpe_meas_t  meas_i;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   int          err_total = 0;
   int          samples_checked = 0;
   irpe_row_t   rows [5] = '{'{32'h5, 32'h5}, '{32'h3, 32'h5}, '{32'h9, 32'h9}, '{32'h9, 32'h9},
                             '{32'h2, 32'h9}};

   always #2.5 mclk_i = ~mclk_i;

   irpe_top irpe_top_inst (
      .mclk_i, .rst_b_i, .clk_en_i, .meas_vld_i, .meas_i, .view_sel_i,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .integ_active_o
   );

   // ==========================================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic tmo();
      err_total++;
      $display("CHECK FAILED wait expected done seen timeout");
      stop_test();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'h1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'h1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge mclk_i);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
         begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
      if (n == 100)
         tmo();
   endtask

   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge mclk_i);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'h1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge mclk_i);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
      if (n == 100)
         tmo();
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      rdr(a, rd);
      chk(nm, rd, e);
   endtask

   // one period result: current peak ip, rms current and the voltage values follow it, power p, dc amps dc
   task automatic ms(input logic [31:0] ip, input logic [31:0] p, input logic [31:0] dc);
      @(posedge mclk_i);
      meas_vld_i <= 1'h1;
      meas_i     <= '{ip, ip + 32'h1, ip + 32'h2, ip + 32'h3, p, dc};
      @(posedge mclk_i);
      meas_vld_i <= 1'h0;
   endtask

   // ==========================================================================
   // main sequence
   initial
   begin
      int i;
      int k;
      int n;
      rst_b_i = 1'h0;
      clk_en_i = 1'h1;
      meas_vld_i = 1'h0;
      meas_i = '0;
      view_sel_i = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'h1;
      rc(OFS_STATUS, 32'h0, "status");
      chk("rresp_ok", 32'(resp), 32'(RESP_OKAY));
      rc(OFS_IPK, 32'h0, "ipk");
      rc(8'h3C, 32'h0, "unmapped");
      chk("rresp", 32'(resp), 32'(RESP_SLVERR));
      rc(8'h05, 32'h0, "misaligned");
      chk("rresp", 32'(resp), 32'(RESP_SLVERR));
      wr(8'h3C, 32'h1);
      chk("bresp", 32'(resp), 32'(RESP_SLVERR));
      // running maxima table
      for (i = 0; i < 5; i++)
      begin
         view_sel_i <= i[0];
         ms(rows[i].v, rows[i].v + 32'h4, 32'h0);
         for (k = 0; k < 5; k++)
            rc(OFS_IPK + 8'(4 * k), rows[i].e + 32'(k), "max");
      end
      // frozen enable ignores a period
      clk_en_i <= 1'h0;
      ms(32'h50, 32'h54, 32'h0);
      clk_en_i <= 1'h1;
      rc(OFS_IPK, 32'h9, "ipk_frozen");
      // clear then fresh maxima
      wr(OFS_CTRL, 32'h1);
      rc(OFS_IPK, 32'h0, "ipk_clr");
      rc(OFS_PWR, 32'h0, "pwr_clr");
      ms(32'h1, 32'h5, 32'h0);
      rc(OFS_IPK, 32'h1, "ipk_new");
      rc(OFS_VRMS, 32'h4, "vrms_new");
      // manual integration with ac coupling
      wr(OFS_CFG, 32'h0);
      wr(OFS_CTRL, 32'h2);
      chk("active", 32'(integ_active_o), 32'h1);
      ms(32'h0, 32'hA, 32'h3);
      view_sel_i <= 1'h1;
      ms(32'h0, 32'hFFFF_FFFC, 32'hFFFF_FFFE);
      ms(32'h0, 32'h6, 32'h0);
      wr(OFS_CFG, 32'h2);
      chk("bresp_locked", 32'(resp), 32'(RESP_OKAY));
      rc(OFS_CFG, 32'h0, "cfg_locked");
      rc(OFS_BOUGHT, 32'h10, "bought");
      rc(OFS_SOLD, 32'h4, "sold");
      rc(OFS_CHARGE, 32'h0, "charge_hidden");
      rc(OFS_DISCH, 32'h0, "disch_hidden");
      rc(OFS_TOTAL, 32'hC, "total");
      wr(OFS_CTRL, 32'h4);
      ms(32'h0, 32'h64, 32'h0);
      rc(OFS_TOTAL, 32'hC, "total_stopped");
      chk("active", 32'(integ_active_o), 32'h0);
      // direct-only coupling, restart clears
      wr(OFS_CFG, 32'h2);
      wr(OFS_CTRL, 32'h2);
      rc(OFS_TOTAL, 32'h0, "total_restart");
      ms(32'h0, 32'h0, 32'h7);
      ms(32'h0, 32'h0, 32'hFFFF_FFFD);
      rc(OFS_CHARGE, 32'h7, "charge");
      rc(OFS_DISCH, 32'h3, "disch");
      rc(OFS_BOUGHT, 32'h0, "bought_hidden");
      rc(OFS_SOLD, 32'h0, "sold_hidden");
      wr(OFS_CTRL, 32'h4);
      // timed run: delay, run, automatic stop
      wr(OFS_CFG, 32'h1);
      wr(OFS_DELAY, 32'h14);
      wr(OFS_RUNTIME, 32'hC8);
      wr(OFS_CTRL, 32'h2);
      rc(OFS_STATUS, 32'h3, "status_delay");
      ms(32'h0, 32'h32, 32'h0);
      repeat (30) @(posedge mclk_i);
      rc(OFS_STATUS, 32'h1, "status_run");
      ms(32'h0, 32'h7, 32'h0);
      for (n = 0; n < 400 && integ_active_o !== 1'h0; n++)
         @(posedge mclk_i);
      if (n == 400)
         tmo();
      ms(32'h0, 32'h9, 32'h0);
      rc(OFS_TOTAL, 32'h7, "total_timed");
      rc(OFS_BOUGHT, 32'h7, "bought_timed");
      // zero delay, then manual stop mid-run
      wr(OFS_DELAY, 32'h0);
      wr(OFS_CTRL, 32'h2);
      rc(OFS_STATUS, 32'h1, "status_nodelay");
      wr(OFS_CTRL, 32'h4);
      chk("active", 32'(integ_active_o), 32'h0);
      // reset in mid-run
      wr(OFS_CTRL, 32'h2);
      rst_b_i <= 1'h0;
      repeat (2) @(posedge mclk_i);
      chk("active_rst", 32'(integ_active_o), 32'h0);
      rst_b_i <= 1'h1;
      rc(OFS_IPK, 32'h0, "ipk_rst");
      rc(OFS_CFG, 32'h0, "cfg_rst");
      stop_test();
   end
endmodule
